// >>> hw/php_consts.svh
// constants for the parallel host port: widths and host strobe timing
// assumes core_clk at 100 MHz on both ends of the port
`ifndef PHP_CONSTS_SVH
`define PHP_CONSTS_SVH

// ==========================================================
// bus widths
`define PHP_ADDR_W 13
`define PHP_DATA_W 8

// ==========================================================
// host timing, as times in ns and derived cycle counts
`define PHP_CLK_PERIOD_NS 10
`define PHP_SETUP_NS 20
`define PHP_STROBE_NS 100
`define PHP_HOLD_NS 20
// least times round up to whole cycles
`define PHP_SETUP_CYC ((`PHP_SETUP_NS + `PHP_CLK_PERIOD_NS - 1) / `PHP_CLK_PERIOD_NS)
`define PHP_STROBE_CYC ((`PHP_STROBE_NS + `PHP_CLK_PERIOD_NS - 1) / `PHP_CLK_PERIOD_NS)
`define PHP_HOLD_CYC ((`PHP_HOLD_NS + `PHP_CLK_PERIOD_NS - 1) / `PHP_CLK_PERIOD_NS)
`define PHP_CNT_W 8

// ==========================================================
// pin levels
`define PHP_STYLE_SEPARATE 1'b0
`define PHP_STYLE_DIRECTION 1'b1
`define PHP_DATA_IDLE 8'hff

`endif

// >>> hw/php_pkg.sv
// types shared by both ends of the parallel host port
// assumes php_consts.svh is on the include path
`include "php_consts.svh"

package php_pkg;

	// ==========================================================
	// host sequencing states
	typedef enum logic [1:0]
	{
		HOST_IDLE,
		HOST_SETUP,
		HOST_STROBE,
		HOST_HOLD
	} host_state_t;

	// ==========================================================
	// one sample of every pin the device watches
	typedef struct packed
	{
		logic                    chipSelectN;
		logic                    readStrobeN;
		logic                    writeStrobeN;
		logic                    readNotWrite;
		logic                    dataStrobeN;
		logic                    busStyleSelect;
		logic [`PHP_ADDR_W-1:0]  addr;
		logic [`PHP_DATA_W-1:0]  data;
		logic                    ioDriveEnable;
		logic                    testPortResetN;
	} pin_sample_t;

endpackage : php_pkg

// >>> hw/php_if.sv
// the pins between a host and the device, with wire resolution
// assumes both ends run on one core_clk; undriven lines float high
`include "php_consts.svh"

interface php_if;
	logic                   busStyleSelect;
	logic                   chipSelectN;
	logic                   readStrobeN;
	logic                   writeStrobeN;
	logic                   readNotWrite;
	logic                   dataStrobeN;
	logic [`PHP_ADDR_W-1:0] addr;
	logic [`PHP_DATA_W-1:0] hostData;
	logic                   hostDataOe;
	logic [`PHP_DATA_W-1:0] devData;
	logic                   devDataOe;
	logic                   irqOe;
	logic [`PHP_DATA_W-1:0] data;
	logic                   interruptRequestN;

	// ==========================================================
	// resolved lines; a pull-up holds them when nobody drives
	assign data = hostDataOe ? hostData : (devDataOe ? devData : `PHP_DATA_IDLE);
	assign interruptRequestN = ~irqOe;

	modport host
	(
		output busStyleSelect, chipSelectN, readStrobeN, writeStrobeN,
		output readNotWrite, dataStrobeN, addr, hostData, hostDataOe,
		input  data, interruptRequestN
	);

	modport device
	(
		input  busStyleSelect, chipSelectN, readStrobeN, writeStrobeN,
		input  readNotWrite, dataStrobeN, addr, data,
		output devData, devDataOe, irqOe
	);
endinterface : php_if

// >>> hw/php_host_end.sv
// host end of the parallel host port: one access per user request
// assumes the device end answers reads within the strobe time
`include "php_consts.svh"

module php_host_end #(
	parameter int SETUP_CYC  = `PHP_SETUP_CYC,
	parameter int STROBE_CYC = `PHP_STROBE_CYC,
	parameter int HOLD_CYC   = `PHP_HOLD_CYC
) (
	input  wire logic                   core_clk,
	input  wire logic                   reset_n,
	php_if.host                         bus,
	input  wire logic                   busStyleSelect,
	input  wire logic                   reqValid,
	input  wire logic                   reqWrite,
	input  wire logic [`PHP_ADDR_W-1:0] reqAddr,
	input  wire logic [`PHP_DATA_W-1:0] reqData,
	output logic                        reqReady,
	output logic                        respValid,
	output logic [`PHP_DATA_W-1:0]      respData,
	output logic                        irqPending
);

	php_pkg::host_state_t    state_r;
	logic [`PHP_CNT_W-1:0]   count_r;
	logic                    write_r;
	logic                    style_r;
	logic                    csN_r;
	logic                    rdN_r;
	logic                    wrN_r;
	logic                    rnw_r;
	logic                    dsN_r;
	logic [`PHP_ADDR_W-1:0]  addr_r;
	logic [`PHP_DATA_W-1:0]  dataOut_r;
	logic                    dataOe_r;
	logic [`PHP_DATA_W-1:0]  dataSyncA_r;
	logic [`PHP_DATA_W-1:0]  dataSyncB_r;
	logic                    irqSyncA_r;
	logic                    irqSyncB_r;
	logic                    take;
	logic                    lastCycle;

	assign take      = (state_r == php_pkg::HOST_IDLE) && reqValid && reqReady;
	assign lastCycle = (count_r == `PHP_CNT_W'(1));

	// ==========================================================
	// access sequencer
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r <= php_pkg::HOST_IDLE;
			count_r <= '0;
		end
		else
		begin
			case (state_r)
				php_pkg::HOST_IDLE:
				begin
					if (take)
					begin
						state_r <= php_pkg::HOST_SETUP;
						count_r <= `PHP_CNT_W'(SETUP_CYC);
					end
				end
				php_pkg::HOST_SETUP:
				begin
					count_r <= count_r - `PHP_CNT_W'(1);
					if (lastCycle)
					begin
						state_r <= php_pkg::HOST_STROBE;
						count_r <= `PHP_CNT_W'(STROBE_CYC);
					end
				end
				php_pkg::HOST_STROBE:
				begin
					count_r <= count_r - `PHP_CNT_W'(1);
					if (lastCycle)
					begin
						state_r <= php_pkg::HOST_HOLD;
						count_r <= `PHP_CNT_W'(HOLD_CYC);
					end
				end
				php_pkg::HOST_HOLD:
				begin
					count_r <= count_r - `PHP_CNT_W'(1);
					if (lastCycle)
						state_r <= php_pkg::HOST_IDLE;
				end
				default:
				begin
					state_r <= php_pkg::HOST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// request capture; style is frozen for the whole access
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			write_r   <= 1'b0;
			style_r   <= `PHP_STYLE_SEPARATE;
			addr_r    <= '0;
			dataOut_r <= '0;
		end
		else if (take)
		begin
			write_r   <= reqWrite;
			style_r   <= busStyleSelect; // [R02]
			addr_r    <= reqAddr;        // [R03] [R04]
			dataOut_r <= reqData;        // [R04]
		end
	end

	// ==========================================================
	// pin drive: chip select spans setup to hold, strobe in the middle
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			csN_r    <= 1'b1;
			rdN_r    <= 1'b1;
			wrN_r    <= 1'b1;
			rnw_r    <= 1'b1;
			dsN_r    <= 1'b1;
			dataOe_r <= 1'b0;
		end
		else
		begin
			csN_r    <= !(take || (state_r != php_pkg::HOST_IDLE &&
				!(state_r == php_pkg::HOST_HOLD && lastCycle)));  // [R05]
			dataOe_r <= take ? reqWrite : (write_r && state_r != php_pkg::HOST_IDLE &&
				!(state_r == php_pkg::HOST_HOLD && lastCycle));
			if (take)
				rnw_r <= !reqWrite;                                // [R07]
			else if (state_r == php_pkg::HOST_HOLD && lastCycle)
				rnw_r <= 1'b1;
			if (state_r == php_pkg::HOST_SETUP && lastCycle)
			begin
				rdN_r <= !(style_r == `PHP_STYLE_SEPARATE && !write_r); // [R06]
				wrN_r <= !(style_r == `PHP_STYLE_SEPARATE && write_r);  // [R06]
				dsN_r <= !(style_r == `PHP_STYLE_DIRECTION);            // [R08]
			end
			else if (state_r == php_pkg::HOST_STROBE && lastCycle)
			begin
				rdN_r <= 1'b1;
				wrN_r <= 1'b1;
				dsN_r <= 1'b1;
			end
		end
	end

	// ==========================================================
	// input synchronisers and read answer
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dataSyncA_r <= '0;
			dataSyncB_r <= '0;
			irqSyncA_r  <= 1'b1;
			irqSyncB_r  <= 1'b1;
			irqPending  <= 1'b0;
			respValid   <= 1'b0;
			respData    <= '0;
			reqReady    <= 1'b0;
		end
		else
		begin
			dataSyncA_r <= bus.data;
			dataSyncB_r <= dataSyncA_r;
			irqSyncA_r  <= bus.interruptRequestN;
			irqSyncB_r  <= irqSyncA_r;
			irqPending  <= !irqSyncB_r;
			respValid   <= state_r == php_pkg::HOST_STROBE && lastCycle && !write_r;
			if (state_r == php_pkg::HOST_STROBE && lastCycle && !write_r)
				respData <= dataSyncB_r;
			reqReady    <= (state_r == php_pkg::HOST_IDLE && !take) ||
				(state_r == php_pkg::HOST_HOLD && lastCycle);
		end
	end

	assign bus.busStyleSelect = style_r;
	assign bus.chipSelectN    = csN_r;
	assign bus.readStrobeN    = rdN_r;
	assign bus.writeStrobeN   = wrN_r;
	assign bus.readNotWrite   = rnw_r;
	assign bus.dataStrobeN    = dsN_r;
	assign bus.addr           = addr_r;
	assign bus.hostData       = dataOut_r;
	assign bus.hostDataOe     = dataOe_r;

endmodule : php_host_end

// >>> hw/php_device_end.sv
// device end of the parallel host port: turns pin accesses into
// internal register reads and writes, and drives the interrupt line
// assumes all pins are asynchronous to core_clk; the register file
// sits on the user side and answers rdData combinationally from rdAddr
//
// Operation
// [R01] eight-bit two-way data bus, two timing styles
// [R02] style select low separate, high direction
// [R03] full thirteen-bit address selects the location
// [R04] host never multiplexes address and data
// [R05] chip select low required; strobes otherwise ignored
// [R06] separate style: read and write strobes
// [R07] direction style: direction line picks read/write
// [R08] direction style: data strobe times the transfer
// [R09] interrupt low while any unmasked source active
// [R10] enable and test reset low: float outputs
// [R11] drive data only during selected read
// [R12] write captured at strobe release, selected
`include "php_consts.svh"

module php_device_end #(
	parameter int ADDR_W = `PHP_ADDR_W,
	parameter int DATA_W = `PHP_DATA_W,
	parameter int IRQ_W  = 8
) (
	input  wire logic              core_clk,
	input  wire logic              reset_n,
	php_if.device                  bus,
	input  wire logic              ioDriveEnable,
	input  wire logic              testPortResetN,
	input  wire logic [IRQ_W-1:0]  irqSource,
	input  wire logic [IRQ_W-1:0]  irqMask,
	input  wire logic [DATA_W-1:0] rdData,
	output logic                   rdStrobe,
	output logic [ADDR_W-1:0]      rdAddr,
	output logic                   wrStrobe,
	output logic [ADDR_W-1:0]      wrAddr,
	output logic [DATA_W-1:0]      wrData,
	output logic                   busFloating
);

	// ==========================================================
	// access decode shared by both pipeline stages
	function automatic logic readActive(input php_pkg::pin_sample_t p);
		if (p.chipSelectN)
			return 1'b0;                                  // [R05]
		if (p.busStyleSelect == `PHP_STYLE_DIRECTION)
			return p.readNotWrite && !p.dataStrobeN;      // [R07] [R08]
		return !p.readStrobeN;                            // [R06]
	endfunction : readActive

	function automatic logic writeActive(input php_pkg::pin_sample_t p);
		if (p.chipSelectN)
			return 1'b0;                                  // [R05]
		if (p.busStyleSelect == `PHP_STYLE_DIRECTION)
			return !p.readNotWrite && !p.dataStrobeN;     // [R07] [R08]
		return !p.writeStrobeN;                           // [R06]
	endfunction : writeActive

	function automatic logic floatRequested(input php_pkg::pin_sample_t p);
		return !p.ioDriveEnable && !p.testPortResetN;    // [R10]
	endfunction : floatRequested

	php_pkg::pin_sample_t pinRaw;
	php_pkg::pin_sample_t syncA_r;
	php_pkg::pin_sample_t syncB_r;
	php_pkg::pin_sample_t prev_r;
	logic                 readNow;
	logic                 readBefore;
	logic                 writeNow;
	logic                 writeBefore;
	logic                 floatNow;
	logic [DATA_W-1:0]    dataOut_r;
	logic                 dataOe_r;
	logic                 irqOe_r;

	// ==========================================================
	// pin sampling: every pin passes two flip-flops before decode
	always_comb
	begin
		pinRaw                = '0;
		pinRaw.chipSelectN    = bus.chipSelectN;
		pinRaw.readStrobeN    = bus.readStrobeN;
		pinRaw.writeStrobeN   = bus.writeStrobeN;
		pinRaw.readNotWrite   = bus.readNotWrite;
		pinRaw.dataStrobeN    = bus.dataStrobeN;
		pinRaw.busStyleSelect = bus.busStyleSelect;  // [R02]
		pinRaw.addr           = bus.addr;
		pinRaw.data           = bus.data;            // [R01]
		pinRaw.ioDriveEnable  = ioDriveEnable;
		pinRaw.testPortResetN = testPortResetN;
	end

	// the idle value keeps chip select and strobes released after reset
	localparam php_pkg::pin_sample_t PIN_IDLE = '{
		chipSelectN:    1'b1,
		readStrobeN:    1'b1,
		writeStrobeN:   1'b1,
		readNotWrite:   1'b1,
		dataStrobeN:    1'b1,
		busStyleSelect: `PHP_STYLE_SEPARATE,
		addr:           '0,
		data:           '0,
		ioDriveEnable:  1'b1,
		testPortResetN: 1'b1
	};

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			syncA_r <= PIN_IDLE;
			syncB_r <= PIN_IDLE;
			prev_r  <= PIN_IDLE;
		end
		else
		begin
			syncA_r <= pinRaw;
			syncB_r <= syncA_r;
			prev_r  <= syncB_r;
		end
	end

	assign readNow     = readActive(syncB_r);
	assign readBefore  = readActive(prev_r);
	assign writeNow    = writeActive(syncB_r);
	assign writeBefore = writeActive(prev_r);
	assign floatNow    = floatRequested(syncB_r);

	// ==========================================================
	// write path: prev_r holds the last sample with the strobe still
	// low, so address and data are those present at the release
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wrStrobe <= 1'b0;
			wrAddr   <= '0;
			wrData   <= '0;
		end
		else
		begin
			wrStrobe <= writeBefore && !writeNow && !prev_r.chipSelectN; // [R12]
			if (writeBefore && !writeNow && !prev_r.chipSelectN)
			begin
				wrAddr <= prev_r.addr;                                    // [R03] [R12]
				wrData <= prev_r.data;                                    // [R12]
			end
		end
	end

	// ==========================================================
	// read path: the address follows the pins for the whole strobe,
	// so a host that moves the address late still reads the right byte
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rdStrobe  <= 1'b0;
			rdAddr    <= '0;
			dataOut_r <= '0;
		end
		else
		begin
			rdStrobe <= readNow && !readBefore;
			if (readNow)
				rdAddr <= syncB_r.addr;                  // [R03]
			if (readNow && readBefore)
				dataOut_r <= rdData;
		end
	end

	// ==========================================================
	// bus drive; two cycles of turnaround are lost to the two sync stages
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			dataOe_r <= 1'b0;
		else
			dataOe_r <= readNow && readBefore && !floatNow; // [R11] [R10]
	end

	// ==========================================================
	// interrupt: sources and mask are on core_clk, so no sync here
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			irqOe_r <= 1'b0;
		else
			irqOe_r <= |(irqSource & irqMask) && !floatNow;  // [R09] [R10]
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			busFloating <= 1'b0;
		else
			busFloating <= floatNow;                         // [R10]
	end

	assign bus.devData   = dataOut_r;
	assign bus.devDataOe = dataOe_r;
	assign bus.irqOe     = irqOe_r;

endmodule : php_device_end

// >>> bench/php_asserts.sv
// concurrent checks on the pins between the host end and the device end
// assumes one core_clk domain and the resolved lines of php_if
`include "php_consts.svh"

module php_asserts
(
	input wire logic                   core_clk,
	input wire logic                   reset_n,
	input wire logic                   busStyleSelect,
	input wire logic                   chipSelectN,
	input wire logic                   readStrobeN,
	input wire logic                   writeStrobeN,
	input wire logic                   readNotWrite,
	input wire logic                   dataStrobeN,
	input wire logic [`PHP_ADDR_W-1:0] addr,
	input wire logic [`PHP_DATA_W-1:0] hostData,
	input wire logic                   hostDataOe,
	input wire logic                   devDataOe
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	// ==========================================================
	// access openings and the direction-style hold
	sequence sepRead;
		!chipSelectN && $fell(readStrobeN);
	endsequence

	sequence dirOpen;
		!chipSelectN && $fell(dataStrobeN);
	endsequence

	sequence dirHold;
		(!dataStrobeN && $stable(readNotWrite)) [*8];
	endsequence

	// ==========================================================
	// pin checks
	a_no_bus_fight: assert property (!(hostDataOe && devDataOe))
		else $error("host and device drive data together");
	a_strobe_needs_cs: assert property (
		(!readStrobeN || !writeStrobeN || !dataStrobeN) |-> !chipSelectN)
		else $error("strobe without chip select");
	a_sep_style_pins: assert property (!chipSelectN && !busStyleSelect |-> dataStrobeN)
		else $error("data strobe used in separate style");
	a_dir_style_pins: assert property (
		!chipSelectN && busStyleSelect |-> readStrobeN && writeStrobeN)
		else $error("read or write strobe used in direction style");
	a_sep_read_width: assert property (sepRead |-> !readStrobeN [*8])
		else $error("read strobe too short");
	a_dir_access_hold: assert property (dirOpen |-> dirHold)
		else $error("direction changed under data strobe");
	a_drive_on_read: assert property (
		$rose(devDataOe) |-> !chipSelectN &&
		(busStyleSelect ? (readNotWrite && !dataStrobeN) : !readStrobeN))
		else $error("device drives data outside a read");
	a_drive_release: assert property ($rose(chipSelectN) |-> ##[1:3] !devDataOe)
		else $error("device keeps driving after deselect");
	a_write_data_held: assert property (
		!chipSelectN && (!writeStrobeN ||
		(busStyleSelect && !readNotWrite && !dataStrobeN)) |-> hostDataOe)
		else $error("write strobe without host data");
	a_addr_stable: assert property (
		!chipSelectN && !$past(chipSelectN) |-> $stable(addr))
		else $error("address moved during access");
	a_write_data_steady: assert property (
		hostDataOe && $past(hostDataOe) |-> $stable(hostData))
		else $error("host data moved while driven");
endmodule : php_asserts

// >>> bench/parallel_host_bus_port_test.sv
// self-checking bench: host end and device end joined by php_if
// assumes the design files under hw/ and php_asserts are compiled first
`include "php_consts.svh"

module parallel_host_bus_port_test;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {bit wr; logic [`PHP_ADDR_W-1:0] a; logic [`PHP_DATA_W-1:0] d;} note_t;

	logic                   core_clk;
	logic                   reset_n;
	logic                   style;
	logic                   reqValid;
	logic                   reqWrite;
	logic                   reqReady;
	logic                   respValid;
	logic                   irqPending;
	logic [`PHP_ADDR_W-1:0] reqAddr;
	logic [`PHP_DATA_W-1:0] reqData;
	logic [`PHP_DATA_W-1:0] respData;
	logic                   ioDriveEnable;
	logic                   testPortResetN;
	logic [7:0]             irqSource;
	logic [7:0]             irqMask;
	logic [`PHP_DATA_W-1:0] rdData;
	logic                   rdStrobe;
	logic                   wrStrobe;
	logic                   busFloating;
	logic [`PHP_ADDR_W-1:0] rdAddr;
	logic [`PHP_ADDR_W-1:0] wrAddr;
	logic [`PHP_DATA_W-1:0] wrData;
	logic                   rRd;
	logic                   rWr;
	logic                   rogueHits;
	logic [`PHP_ADDR_W-1:0] a;
	logic [`PHP_DATA_W-1:0] d;
	bit                     w;
	note_t                  n;
	note_t                  notes[$];
	int                     badCount;
	int                     nChecks;

	php_if bus();
	php_if rogueBus();

	// the register file stub mixes the high address bits into the byte
	assign rdData = rdAddr[7:0] ^ {3'h0, rdAddr[12:8]};

	php_host_end php_host_end_inst (.core_clk(core_clk), .reset_n(reset_n), .bus(bus),
		.busStyleSelect(style), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
		.reqData(reqData), .reqReady(reqReady), .respValid(respValid), .respData(respData),
		.irqPending(irqPending));
	php_device_end php_device_end_inst (.core_clk(core_clk), .reset_n(reset_n), .bus(bus),
		.ioDriveEnable(ioDriveEnable), .testPortResetN(testPortResetN), .irqSource(irqSource),
		.irqMask(irqMask), .rdData(rdData), .rdStrobe(rdStrobe), .rdAddr(rdAddr),
		.wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData), .busFloating(busFloating));
	// second device whose pins the bench drives, to break the select rule on purpose
	php_device_end rogue_php_device_end_inst (.core_clk(core_clk), .reset_n(reset_n),
		.bus(rogueBus), .ioDriveEnable(ioDriveEnable), .testPortResetN(testPortResetN),
		.irqSource(irqSource), .irqMask(irqMask), .rdData(8'h00), .rdStrobe(rRd), .rdAddr(),
		.wrStrobe(rWr), .wrAddr(), .wrData(), .busFloating());
	php_asserts php_asserts_inst (.core_clk(core_clk), .reset_n(reset_n),
		.busStyleSelect(bus.busStyleSelect), .chipSelectN(bus.chipSelectN),
		.readStrobeN(bus.readStrobeN), .writeStrobeN(bus.writeStrobeN),
		.readNotWrite(bus.readNotWrite), .dataStrobeN(bus.dataStrobeN), .addr(bus.addr),
		.hostData(bus.hostData), .hostDataOe(bus.hostDataOe), .devDataOe(bus.devDataOe));

	function automatic bit miss(input bit m);
		nChecks++;
		return m;
	endfunction : miss

	function automatic logic [7:0] rdModel(input logic [`PHP_ADDR_W-1:0] x);
		return x[7:0] ^ {3'h0, x[12:8]};
	endfunction : rdModel

	task automatic fail(input string m);
		badCount++;
		$display("[FAIL] %0t %s", $time, m);
	endtask : fail

	task summarize;
		$display("TB: %0d checks, %0d mismatches", nChecks, badCount);
		if (badCount == 0 && nChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	// one host access; the expectation is noted before the result can appear
	task automatic access(input bit wr, input logic [12:0] x, input logic [7:0] v,
		input logic [7:0] e);
		int k = 0;
		@(posedge core_clk);
		reqValid <= 1'b1;
		reqWrite <= wr;
		reqAddr <= x;
		reqData <= v;
		notes.push_back('{wr, x, wr ? v : e});
		do
		begin
			@(posedge core_clk);
			k++;
		end
		while (reqReady !== 1'b1 && k < 100);
		reqValid <= 1'b0;
		if (miss(k >= 100)) fail("request not taken");
	endtask : access

	// ==========================================================
	// result watcher
	always @(posedge core_clk)
	begin
		if (reset_n && (respValid === 1'b1 || wrStrobe === 1'b1))
		begin
			if (miss(notes.size() == 0)) fail("unexpected result");
			else
			begin
				n = notes.pop_front();
				if (miss(wrStrobe !== n.wr)) fail("result kind");
				else if (n.wr && miss({wrAddr, wrData} !== {n.a, n.d})) fail("write capture");
				else if (!n.wr && miss(respData !== n.d)) fail("read data");
			end
		end
		if (rdStrobe === 1'b1 && miss(notes.size() == 0 ||
			notes[0].wr || rdAddr !== notes[0].a)) fail("read start");
		if (rRd === 1'b1 || rWr === 1'b1 || rogueBus.devDataOe === 1'b1)
			rogueHits <= 1'b1;
	end

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial
	begin
		repeat (5000) @(posedge core_clk);
		fail("watchdog expired");
		summarize();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		{reset_n, style, reqValid, reqWrite, reqAddr, reqData} = '0;
		{ioDriveEnable, testPortResetN, irqSource, irqMask, rogueHits} = {2'b11, 17'h0_0000};
		{rogueBus.busStyleSelect, rogueBus.addr, rogueBus.hostData, rogueBus.hostDataOe} = '0;
		{rogueBus.chipSelectN, rogueBus.readStrobeN, rogueBus.writeStrobeN} = 3'h7;
		{rogueBus.readNotWrite, rogueBus.dataStrobeN} = 2'h3;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		void'($urandom(79057));
		for (int s = 0; s < 2; s++)
		begin
			@(posedge core_clk);
			style <= s[0];
			access(1'b1, 13'h1fff, 8'ha5, 8'h00);
			access(1'b0, 13'h1fff, 8'h00, rdModel(13'h1fff));
			access(1'b0, 13'h0000, 8'h00, rdModel(13'h0000));
			for (int i = 0; i < 8; i++)
			begin
				{a, d, w} = 22'($urandom);
				access(w, a, d, rdModel(a));
			end
			$display("TB: access test in style %0d done", s);
		end
		for (int i = 0; i < 8; i++)
		begin
			irqSource <= 8'h01 << i;
			irqMask <= ~(8'h01 << i);
			repeat (6) @(posedge core_clk);
			if (miss(irqPending !== 1'b0 || bus.interruptRequestN !== 1'b1)) fail("masked irq");
			irqMask <= 8'h01 << i;
			repeat (6) @(posedge core_clk);
			if (miss(irqPending !== 1'b1 || bus.interruptRequestN !== 1'b0)) fail("irq lost");
		end
		$display("TB: interrupt test done");
		for (int c = 0; c < 4; c++)
		begin
			ioDriveEnable <= c[0];
			testPortResetN <= c[1];
			repeat (6) @(posedge core_clk);
			if (miss(busFloating !== 1'(c == 0))) fail("float state");
			if (miss(bus.interruptRequestN !== 1'(c == 0))) fail("irq while floating");
			if (c == 0)
				access(1'b0, 13'h0123, 8'h00, 8'hff);
			repeat (20) @(posedge core_clk);
		end
		$display("TB: float test done");
		for (int k = 0; k < 4; k++)
		begin
			rogueBus.busStyleSelect <= k[1];
			rogueBus.readNotWrite <= k[0];
			rogueBus.hostDataOe <= ~k[0];
			@(posedge core_clk);
			rogueBus.readStrobeN <= ~k[0];
			rogueBus.writeStrobeN <= k[0];
			rogueBus.dataStrobeN <= 1'b0;
			repeat (10) @(posedge core_clk);
			{rogueBus.readStrobeN, rogueBus.writeStrobeN, rogueBus.dataStrobeN} <= 3'h7;
			repeat (6) @(posedge core_clk);
		end
		if (miss(rogueHits !== 1'b0)) fail("strobe taken while deselected");
		$display("TB: deselect test done");
		repeat (30) @(posedge core_clk);
		if (miss(notes.size() != 0)) fail("results missing");
		summarize();
	end
endmodule : parallel_host_bus_port_test
